// File: core/pwr_defines.svh
// Offsets, field positions, reset values and timing counts of the power stage
`ifndef PWR_DEFINES_SVH
`define PWR_DEFINES_SVH
// Stage window stride, group window base and stride (bytes)
`define PWR_STAGE_STRIDE 12'h080
`define PWR_GRP_BASE 7'h40
`define PWR_GRP_STRIDE 7'h10
// Per-stage register offsets
`define PWR_CFG 7'h00
`define PWR_STATUS 7'h04
`define PWR_RATIO_SET 7'h08
`define PWR_RATIO_NOM 7'h0c
`define PWR_REMAIN 7'h10
`define PWR_CNT_START 7'h14
`define PWR_CNT_TRIP 7'h18
`define PWR_CNT_BLK 7'h1c
`define PWR_CNT_CLR 7'h20
`define PWR_EV_MASK 7'h24
`define PWR_MEAS 7'h28
// Per-group register offsets inside a group window
`define PWR_G_PICK 4'h0
`define PWR_G_CFG 4'h4
`define PWR_G_NOM 4'h8
// Field positions
`define PWR_CFG_MODE 2:0
`define PWR_CFG_FEN 3
`define PWR_CFG_FSTS 5:4
`define PWR_CFG_SIDE 6
`define PWR_GC_MAG 1:0
`define PWR_GC_DIR 2
`define PWR_GC_NSRC 4:3
`define PWR_GC_DLY 31:16
// Reset values
`define PWR_NOM_RST 32'h000186a0
`define PWR_PICK_RST 18'h00000
`define PWR_EVMASK_RST 6'h3f
// Scaling: pick-up steps per 100 %, hysteresis percents, per-unit scale
`define PWR_PCT_FULL 20000
`define PWR_HYS_OVER 97
`define PWR_HYS_UNDER 103
`define PWR_PU_SCALE 100
// Program cycle time base
`define PWR_TICK_NS 5000000
`define PWR_CLK_NS 4
`endif

// File: core/pwr_pkg.sv
// Types shared by the power stage
package pwr_pkg;
    // Operating modes in register encoding order
    typedef enum logic [2:0] {MODE_ON, MODE_BLOCKED, MODE_TEST, MODE_TEST_BLK, MODE_OFF} pwr_mode_t;
    // Reported condition
    typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} pwr_cond_t;
    // Compared quantity
    typedef enum logic [1:0] {MAG_ACTIVE, MAG_REACTIVE, MAG_APPARENT} pwr_mag_t;
    // Nominal source
    typedef enum logic [1:0] {NOM_MANUAL, NOM_GEN, NOM_TRAFO} pwr_nsrc_t;
    // Event kinds
    typedef enum logic [2:0] {EV_START_ON, EV_START_OFF, EV_TRIP_ON, EV_TRIP_OFF,
        EV_BLK_ON, EV_BLK_OFF} pwr_ev_t;
endpackage

// File: core/pwr_stage.sv
// Four-stage over/under power protection with APB settings and event output
//
// Functional notes
// - Take new measurements every 5 ms
// - Select active, reactive or apparent power
// - Over or under pick-up direction, over default
// - Release at 97 % over, 103 % under
// - Signed pick-up percent, 0.005 % steps
// - Nominal from manual, generator or transformer
// - Manual nominal 0.0001 MVA, default 10 MVA
// - Choose power module one or two
// - Modes on, blocked, test, test-blocked, off
// - Forced status normal, start, trip, blocked
// - Mode, force, side are static settings
// - Pick-up from active group, live change
// - Always report one of four conditions
// - Measured over pick-up ratio, 0.01 pu
// - Measured over nominal ratio, 0.01 pu
// - Remaining time to trip, 5 ms steps
// - Sample block at each cycle start
// - Pick-up without block starts timing
// - Pick-up with block reports blocked only
// - Block after start clears start, timer
// - Definite-time delay from start to trip
// - Four independent stages with own events
// - Selectable time-stamped on/off events
// - Resettable start, trip, blocked counters
`timescale 1ns/10ps
`include "pwr_defines.svh"
module pwr_stage
    import pwr_pkg::*;
#(
    parameter int STAGES = 4,
    parameter int GROUPS = 2,
    parameter int CYCLE_TICKS = `PWR_TICK_NS / `PWR_CLK_NS
) (
    // APB slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Power module one: P, Q, S in 0.0001 MVA
    input wire logic signed [31:0] pm1_p,
    input wire logic signed [31:0] pm1_q,
    input wire logic signed [31:0] pm1_s,
    // Power module two
    input wire logic signed [31:0] pm2_p,
    input wire logic signed [31:0] pm2_q,
    input wire logic signed [31:0] pm2_s,
    // Nominal ratings from monitoring, 0.0001 MVA
    input wire logic [31:0] gen_nom,
    input wire logic [31:0] trafo_nom,
    // Blocking matrix and group selection
    input wire logic [STAGES-1:0] block_in,
    input wire logic [$clog2(GROUPS)-1:0] active_group,
    // Stage outputs
    output logic [STAGES-1:0] start_out,
    output logic [STAGES-1:0] trip_out,
    output logic [STAGES-1:0] blocked_out,
    // Event stream
    output logic ev_valid,
    output logic [1:0] ev_stage,
    output logic [2:0] ev_code,
    output logic [31:0] ev_stamp
);
    localparam int SW = $clog2(STAGES);
    localparam int GW = $clog2(GROUPS);
    localparam int EVN = STAGES * 6;

    // Signed divide guarded against zero
    function automatic logic signed [31:0] ratio(input logic signed [63:0] num,
                                                 input logic signed [63:0] den);
        logic signed [63:0] q;
        q = 64'sd0;
        if (den != 64'sd0) begin
            q = (num * `PWR_PU_SCALE) / den;
        end
        return q[31:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Settings and state
    logic [2:0] cfg_mode [STAGES];        // Static mode
    logic cfg_fen [STAGES];               // Forcing enable
    logic [1:0] cfg_fsts [STAGES];        // Forced status
    logic cfg_side [STAGES];              // Module select
    logic [5:0] ev_mask [STAGES];         // Event record enables
    logic signed [17:0] g_pick [STAGES][GROUPS];  // Pick-up, 0.005 % steps
    logic [31:0] g_cfg [STAGES][GROUPS];  // Magnitude, direction, source, delay
    logic [31:0] g_nom [STAGES][GROUPS];  // Manual nominal
    logic pu_r [STAGES];                  // Pick-up comparator state
    logic [15:0] tmr [STAGES];            // Ticks since start
    logic [1:0] cond_r [STAGES];          // Reported condition
    logic signed [31:0] rset_r [STAGES];  // Meas over pick-up
    logic signed [31:0] rnom_r [STAGES];  // Meas over nominal
    logic [15:0] remain_r [STAGES];       // Ticks left to trip
    logic signed [31:0] meas_r [STAGES];  // Selected power
    logic [15:0] cnt [STAGES][3];         // Start, trip, blocked counters
    logic [EVN-1:0] ev_pend;              // Pending events
    logic [31:0] tick_cnt;                // Program cycle counter
    logic [31:0] stamp;                   // Time stamp in cycles
    logic tick;                           // Program cycle pulse

    // Bus decode
    logic acc;
    logic [SW-1:0] a_st;
    logic [6:0] a_off;
    logic a_grp;
    logic [GW-1:0] a_gi;
    logic [3:0] a_goff;
    assign acc = psel & penable & ~pready;
    assign a_st = paddr[7+:SW];
    assign a_off = paddr[6:0];
    assign a_grp = a_off >= `PWR_GRP_BASE;
    assign a_gi = GW'((a_off - `PWR_GRP_BASE) >> 4);
    assign a_goff = a_off[3:0];

    ////////////////////////////////////////////////////////////////////////////
    // Program cycle tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0;
            tick <= 1'b0;
            stamp <= 32'h0;
        end else begin
            tick <= tick_cnt == 32'(CYCLE_TICKS - 1);
            tick_cnt <= (tick_cnt == 32'(CYCLE_TICKS - 1)) ? 32'h0 : tick_cnt + 32'h1;
            if (tick) begin
                stamp <= stamp + 32'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-stage evaluation at each tick
    logic next_pu [STAGES];
    logic next_st [STAGES];
    logic next_tr [STAGES];
    logic next_bk [STAGES];
    logic eff_blk [STAGES];
    logic [15:0] next_tmr [STAGES];
    logic signed [31:0] sel_meas [STAGES];
    logic signed [63:0] nom_use [STAGES];
    logic signed [63:0] lvl [STAGES];
    logic [31:0] gc [STAGES];
    logic [1:0] cur_st [STAGES];

    always_comb begin
        for (int i = 0; i < STAGES; i++) begin
            logic signed [63:0] m;
            logic signed [63:0] rel;
            logic [15:0] dly;
            m = 64'sd0;
            rel = 64'sd0;
            gc[i] = g_cfg[i][active_group];
            dly = gc[i][`PWR_GC_DLY];
            cur_st[i] = cond_r[i];
            unique case (gc[i][`PWR_GC_MAG])
                2'h0: sel_meas[i] = cfg_side[i] ? pm2_p : pm1_p;
                2'h1: sel_meas[i] = cfg_side[i] ? pm2_q : pm1_q;
                default: sel_meas[i] = cfg_side[i] ? pm2_s : pm1_s;
            endcase
            // nominal source, manual for code 0 and the unused code 3
            unique case (gc[i][`PWR_GC_NSRC])
                2'h1: nom_use[i] = 64'(gen_nom);
                2'h2: nom_use[i] = 64'(trafo_nom);
                default: nom_use[i] = 64'(g_nom[i][active_group]);
            endcase
            // level from signed percent of nominal
            lvl[i] = (64'(g_pick[i][active_group]) * nom_use[i]) / `PWR_PCT_FULL;
            m = 64'(sel_meas[i]);
            if (!gc[i][`PWR_GC_DIR]) begin
                rel = (lvl[i] * `PWR_HYS_OVER) / 100;
                next_pu[i] = pu_r[i] ? (m >= rel) : (m > lvl[i]);
            end else begin
                rel = (lvl[i] * `PWR_HYS_UNDER) / 100;
                next_pu[i] = pu_r[i] ? (m <= rel) : (m < lvl[i]);
            end
            // block taken with the cycle's samples
            eff_blk[i] = block_in[i] || cfg_mode[i] == 3'(MODE_BLOCKED)
                         || cfg_mode[i] == 3'(MODE_TEST_BLK);
            next_st[i] = 1'b0;
            next_tr[i] = 1'b0;
            next_bk[i] = 1'b0;
            next_tmr[i] = 16'h0;
            if (cfg_mode[i] > 3'(MODE_TEST_BLK)) begin
                // Off or illegal code: stage idle
                next_pu[i] = 1'b0;
            end else if (next_pu[i] && eff_blk[i]) begin
                next_bk[i] = 1'b1;
            end else if (next_pu[i]) begin
                next_st[i] = 1'b1;
                next_tmr[i] = (cur_st[i] == COND_START || cur_st[i] == COND_TRIP)
                              ? ((tmr[i] == dly) ? tmr[i] : tmr[i] + 16'h1) : 16'h0;
                next_tr[i] = next_tmr[i] >= dly;
            end
        end
    end

    // Condition code from flags
    function automatic logic [1:0] cond_of(input logic st, input logic tr, input logic bk);
        return tr ? 2'(COND_TRIP) : st ? 2'(COND_START) : bk ? 2'(COND_BLOCKED)
               : 2'(COND_NORMAL);
    endfunction

    // Stage state, ratios and outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < STAGES; i++) begin
                pu_r[i] <= 1'b0;
                tmr[i] <= 16'h0;
                cond_r[i] <= 2'(COND_NORMAL);
                rset_r[i] <= 32'sh0;
                rnom_r[i] <= 32'sh0;
                remain_r[i] <= 16'h0;
                meas_r[i] <= 32'sh0;
            end
            start_out <= '0;
            trip_out <= '0;
            blocked_out <= '0;
        end else if (tick) begin
            for (int i = 0; i < STAGES; i++) begin
                logic [1:0] c;
                c = cond_of(next_st[i], next_tr[i], next_bk[i]);
                pu_r[i] <= next_pu[i];
                tmr[i] <= next_tmr[i];
                meas_r[i] <= sel_meas[i];
                rset_r[i] <= ratio(64'(sel_meas[i]), lvl[i]);
                rnom_r[i] <= ratio(64'(sel_meas[i]), nom_use[i]);
                remain_r[i] <= next_st[i] ? gc[i][`PWR_GC_DLY] - next_tmr[i] : 16'h0;
                if (cfg_fen[i]) begin
                    c = cfg_fsts[i];
                end
                cond_r[i] <= c;
                start_out[i] <= c == 2'(COND_START) || c == 2'(COND_TRIP);
                trip_out[i] <= c == 2'(COND_TRIP) && cfg_mode[i] == 3'(MODE_ON);
                blocked_out[i] <= c == 2'(COND_BLOCKED);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Events and counters
    logic [EVN-1:0] ev_new;
    logic [EVN-1:0] ev_take;
    logic [SW+2:0] ev_idx;
    always_comb begin
        ev_new = '0;
        for (int i = 0; i < STAGES; i++) begin
            logic [1:0] o;
            logic [1:0] n;
            logic [5:0] e;
            o = cond_r[i];
            n = cfg_fen[i] ? cfg_fsts[i] : cond_of(next_st[i], next_tr[i], next_bk[i]);
            e[0] = o[1:0] != 2'(COND_START) && o != 2'(COND_TRIP)
                   && (n == 2'(COND_START) || n == 2'(COND_TRIP));
            e[1] = (o == 2'(COND_START) || o == 2'(COND_TRIP))
                   && n != 2'(COND_START) && n != 2'(COND_TRIP);
            e[2] = o != 2'(COND_TRIP) && n == 2'(COND_TRIP);
            e[3] = o == 2'(COND_TRIP) && n != 2'(COND_TRIP);
            e[4] = o != 2'(COND_BLOCKED) && n == 2'(COND_BLOCKED);
            e[5] = o == 2'(COND_BLOCKED) && n != 2'(COND_BLOCKED);
            ev_new[i*6+:6] = tick ? e : 6'h0;
        end
        ev_take = '0;
        ev_idx = '0;
        for (int k = EVN - 1; k >= 0; k--) begin
            if (ev_pend[k]) begin
                ev_idx = (SW+3)'(k);
            end
        end
        if (ev_pend != '0) begin
            ev_take[ev_idx] = 1'b1;
        end
    end

    // Event queue and output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ev_pend <= '0;
            ev_valid <= 1'b0;
            ev_stage <= 2'h0;
            ev_code <= 3'h0;
            ev_stamp <= 32'h0;
        end else begin
            logic [EVN-1:0] msk;
            for (int i = 0; i < STAGES; i++) begin
                msk[i*6+:6] = ev_mask[i];
            end
            // masked, stamped events; new beats taken
            ev_pend <= (ev_pend & ~ev_take) | (ev_new & msk);
            ev_valid <= ev_pend != '0;
            ev_stage <= 2'(ev_idx / 6);
            ev_code <= 3'(ev_idx % 6);
            ev_stamp <= stamp;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave and settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
            for (int i = 0; i < STAGES; i++) begin
                cfg_mode[i] <= 3'(MODE_ON);
                cfg_fen[i] <= 1'b0;
                cfg_fsts[i] <= 2'(COND_NORMAL);
                cfg_side[i] <= 1'b0;
                ev_mask[i] <= `PWR_EVMASK_RST;
                for (int g = 0; g < GROUPS; g++) begin
                    g_pick[i][g] <= `PWR_PICK_RST;
                    g_cfg[i][g] <= 32'h0;
                    g_nom[i][g] <= `PWR_NOM_RST;
                end
                for (int c = 0; c < 3; c++) begin
                    cnt[i][c] <= 16'h0;
                end
            end
        end else begin
            logic bad;
            // Full stage field and group index, so aliases are refused
            bad = 32'(paddr[11:7]) >= 32'(STAGES)
                  || (a_grp && ((32'(a_off) - 32'(`PWR_GRP_BASE)) >> 4) >= 32'(GROUPS));
            pready <= acc;
            pslverr <= acc && bad;
            prdata <= 32'h0;
            for (int i = 0; i < STAGES; i++) begin
                if (ev_new[i*6]) cnt[i][0] <= cnt[i][0] + 16'h1;
                if (ev_new[i*6+2]) cnt[i][1] <= cnt[i][1] + 16'h1;
                if (ev_new[i*6+4]) cnt[i][2] <= cnt[i][2] + 16'h1;
            end
            // Write lands at the edge where the master samples pready high
            if (psel && penable && pready && !bad && pwrite) begin
                if (a_grp) begin
                    unique case (a_goff)
                        `PWR_G_PICK: g_pick[a_st][a_gi] <= pwdata[17:0];
                        `PWR_G_CFG: g_cfg[a_st][a_gi] <= pwdata;
                        `PWR_G_NOM: g_nom[a_st][a_gi] <= pwdata;
                        default: ;
                    endcase
                end else begin
                    unique case (a_off)
                        `PWR_CFG: begin
                            cfg_mode[a_st] <= pwdata[`PWR_CFG_MODE];
                            cfg_fen[a_st] <= pwdata[`PWR_CFG_FEN];
                            cfg_fsts[a_st] <= pwdata[`PWR_CFG_FSTS];
                            cfg_side[a_st] <= pwdata[`PWR_CFG_SIDE];
                        end
                        `PWR_EV_MASK: ev_mask[a_st] <= pwdata[5:0];
                        `PWR_CNT_CLR: begin
                            for (int c = 0; c < 3; c++) begin
                                if (pwdata[c]) begin
                                    cnt[a_st][c] <= {15'h0, ev_new[32'(a_st)*6+c*2]};
                                end
                            end
                        end
                        default: ;
                    endcase
                end
            end else if (acc && !bad && !pwrite) begin
                if (a_grp) begin
                    unique case (a_goff)
                        `PWR_G_PICK: prdata <= 32'(g_pick[a_st][a_gi]);
                        `PWR_G_CFG: prdata <= g_cfg[a_st][a_gi];
                        `PWR_G_NOM: prdata <= g_nom[a_st][a_gi];
                        default: prdata <= 32'h0;
                    endcase
                end else begin
                    unique case (a_off)
                        `PWR_CFG: prdata <= {25'h0, cfg_side[a_st], cfg_fsts[a_st],
                                             cfg_fen[a_st], cfg_mode[a_st]};
                        `PWR_STATUS: prdata <= {27'h0, pu_r[a_st], start_out[a_st],
                                                trip_out[a_st], cond_r[a_st]};
                        `PWR_RATIO_SET: prdata <= rset_r[a_st];
                        `PWR_RATIO_NOM: prdata <= rnom_r[a_st];
                        `PWR_REMAIN: prdata <= {16'h0, remain_r[a_st]};
                        `PWR_CNT_START: prdata <= {16'h0, cnt[a_st][0]};
                        `PWR_CNT_TRIP: prdata <= {16'h0, cnt[a_st][1]};
                        `PWR_CNT_BLK: prdata <= {16'h0, cnt[a_st][2]};
                        `PWR_EV_MASK: prdata <= {26'h0, ev_mask[a_st]};
                        `PWR_MEAS: prdata <= meas_r[a_st];
                        default: prdata <= 32'h0;
                    endcase
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions on stage 0, the bus and the program cycle tick
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_req;
        psel && penable && !pready;
    endsequence
    sequence apb_done;
        pready ##1 !pready;
    endsequence

    apb_answer_a: assert property (apb_req |=> apb_done)
        else $error("apb answer not one cycle");
    block_no_start_a: assert property (tick && eff_blk[0] && next_pu[0] && !cfg_fen[0]
        |=> cond_r[0] == 2'(COND_BLOCKED) && !start_out[0])
        else $error("blocked pick-up started");
    pick_starts_a: assert property (tick && !eff_blk[0] && next_pu[0] && !cfg_fen[0]
        && cfg_mode[0] == 3'(MODE_ON) |=> start_out[0])
        else $error("pick-up did not start");
    trip_with_start_a: assert property (trip_out[0] |-> start_out[0])
        else $error("trip without start");
    cycle_hold_a: assert property (!tick |=> $stable(cond_r[0]))
        else $error("condition moved off cycle");
    force_status_a: assert property (tick && cfg_fen[0] |=> cond_r[0] == $past(cfg_fsts[0]))
        else $error("forced status ignored");
    off_quiet_a: assert property (tick && cfg_mode[0] == 3'(MODE_OFF) && !cfg_fen[0]
        |=> cond_r[0] == 2'(COND_NORMAL) && !trip_out[0])
        else $error("off stage active");
    remain_count_a: assert property (start_out[0] && !cfg_fen[0]
        |-> remain_r[0] == g_cfg[0][active_group][`PWR_GC_DLY] - tmr[0] || $changed(active_group))
        else $error("remaining time wrong");
    tick_period_a: assert property (tick |=> !tick)
        else $error("tick longer than one cycle");
endmodule

// File: tb/pwr_meas_model.sv
// Far-side model: power modules, nominal ratings and block matrix
`timescale 1ns/10ps
module pwr_meas_model (
    // Bench stimulus
    input wire logic signed [31:0] p1,
    input wire logic signed [31:0] p2,
    input wire logic [3:0] blk,
    // Power modules one and two
    output logic signed [31:0] pm1_p,
    output logic signed [31:0] pm1_q,
    output logic signed [31:0] pm1_s,
    output logic signed [31:0] pm2_p,
    output logic signed [31:0] pm2_q,
    output logic signed [31:0] pm2_s,
    // Ratings and blocking
    output logic [31:0] gen_nom,
    output logic [31:0] trafo_nom,
    output logic [3:0] block_in
);
    assign pm1_p = p1;
    assign pm1_q = p1 >>> 1;
    assign pm1_s = p1;
    assign pm2_p = p2;
    assign pm2_q = p2 >>> 1;
    assign pm2_s = p2;
    assign gen_nom = 32'h0001_86a0;
    assign trafo_nom = 32'h0003_0d40;
    assign block_in = blk;
endmodule

// File: tb/power_threshold_protection_tb.sv
// Bench for the power stage: APB setup and stage outputs
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", nm, e, g); end end
module power_threshold_protection_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, active_group = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, gen_nom, trafo_nom, ev_stamp;
    logic pready, pslverr, er, ev_valid;
    logic [1:0] ev_stage;
    logic [2:0] ev_code;
    logic signed [31:0] pm1_p, pm1_q, pm1_s, pm2_p, pm2_q, pm2_s, p1 = 0, p2 = 0;
    logic [3:0] block_in, blk = 4'h0, start_out, trip_out, blocked_out;
    int mismatches = 0, check_count = 0, n;
    int trip_evs = 0;
    logic [31:0] st_stamp = 32'h0, tr_stamp = 32'h0;
    always #2 pclk = ~pclk;
    pwr_meas_model model (.p1, .p2, .blk, .pm1_p, .pm1_q, .pm1_s, .pm2_p, .pm2_q, .pm2_s,
        .gen_nom, .trafo_nom, .block_in);
    pwr_stage #(.CYCLE_TICKS(10)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .pm1_p, .pm1_q, .pm1_s, .pm2_p, .pm2_q, .pm2_s,
        .gen_nom, .trafo_nom, .block_in, .active_group, .start_out, .trip_out, .blocked_out,
        .ev_valid, .ev_stage, .ev_code, .ev_stamp);
    // Event monitor: first stage 0 start-on and trip-on stamps, trip-on count
    always @(posedge pclk) begin
        if (ev_valid === 1'b1 && ev_stage == 2'h0) begin
            if (ev_code == 3'h0 && st_stamp == 32'h0) st_stamp <= ev_stamp;
            if (ev_code == 3'h2 && trip_evs == 0) tr_stamp <= ev_stamp;
            if (ev_code == 3'h2) trip_evs <= trip_evs + 1;
        end
    end
    // One APB transfer, held until pready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (n == 20) mismatches++;
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #40000;
        mismatches++;
        results();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        apb(0, 12'h048, 0);
        `CHK("nom_rst", 32'h186a0, rd)
        apb(0, 12'h024, 0);
        `CHK("evmask", 32'h3f, rd)
        apb(0, 12'h000, 0);
        `CHK("mode_rst", 32'h0, rd)
        apb(0, 12'h200, 0);
        `CHK("stage4", 1'b1, er)
        apb(0, 12'h070, 0);
        `CHK("group3", 1'b1, er)
        // Stages 0,1,3 over 50 % with delay 2 ticks, stage 2 under 80 % with delay 0
        for (int s = 0; s < 4; s++) begin
            apb(1, 12'(s * 128 + 64), (s == 2) ? 32'd16000 : 32'd10000);
            apb(1, 12'(s * 128 + 68), (s == 2) ? 32'h4 : 32'h20000);
        end
        apb(1, 12'h180, 32'h40);
        blk <= 4'h2;
        p1 <= 60000;
        for (n = 0; n < 60 && start_out[0] !== 1'b1; n++) @(posedge pclk);
        `CHK("start0", 1'b1, start_out[0])
        `CHK("trip0_early", 1'b0, trip_out[0])
        `CHK("blk1", 4'h2, blocked_out & 4'h2)
        `CHK("start1", 1'b0, start_out[1])
        `CHK("under2", 1'b1, start_out[2])
        `CHK("side3", 1'b0, start_out[3])
        for (n = 0; n < 60 && trip_out[0] !== 1'b1; n++) @(posedge pclk);
        `CHK("trip_time", 1'b1, n >= 18 && n <= 22)
        apb(0, 12'h008, 0);
        `CHK("ratio_set", 32'd120, rd)
        apb(0, 12'h00c, 0);
        `CHK("ratio_nom", 32'd60, rd)
        `CHK("ev_delay", 32'd2, tr_stamp - st_stamp)
        p1 <= 49000;
        repeat (30) @(posedge pclk);
        `CHK("hys_hold", 1'b1, start_out[0])
        p1 <= 48000;
        for (n = 0; n < 60 && start_out[0] !== 1'b0; n++) @(posedge pclk);
        `CHK("release", 2'b00, {start_out[0], trip_out[0]})
        p1 <= 60000;
        for (n = 0; n < 60 && start_out[0] !== 1'b1; n++) @(posedge pclk);
        blk <= 4'h3;
        for (n = 0; n < 60 && blocked_out[0] !== 1'b1; n++) @(posedge pclk);
        `CHK("blk_after", 2'b01, {start_out[0], blocked_out[0]})
        apb(0, 12'h014, 0);
        `CHK("cnt_start", 32'd2, rd)
        apb(0, 12'h018, 0);
        `CHK("cnt_trip", 32'd1, rd)
        apb(1, 12'h020, 32'h7);
        apb(0, 12'h014, 0);
        `CHK("cnt_clr", 32'd0, rd)
        // Stage 0 off; stage 2 moves to group 1, over 80 %
        apb(1, 12'h000, 32'h4);
        apb(1, 12'h150, 32'd16000);
        active_group <= 1;
        repeat (25) @(posedge pclk);
        `CHK("mode_off", 1'b0, blocked_out[0])
        `CHK("group1", 1'b0, start_out[2])
        // Stage 0 on, forced to trip
        apb(1, 12'h000, 32'h28);
        repeat (25) @(posedge pclk);
        `CHK("forced", 1'b1, trip_out[0])
        `CHK("ev_trips", 2, trip_evs)
        results();
    end
endmodule
